// ---- core/adcsh_cfg.svh ----
// Offsets, field positions and timing counts of the serial converter host
`ifndef ADCSH_CFG_SVH
`define ADCSH_CFG_SVH

// Own APB registers (byte addresses)
`define ADCSH_CTRL_OFS 12'h000
`define ADCSH_CFGW_OFS 12'h004
`define ADCSH_STAT_OFS 12'h008
`define ADCSH_RES_OFS 12'h00C
`define ADCSH_CFGR_OFS 12'h010
`define ADCSH_DIV_OFS 12'h014

// Control register bits (write 1 to start; bit 3 STEN is not decoded)
`define ADCSH_CTRL_CONV 0
`define ADCSH_CTRL_WR 1
`define ADCSH_CTRL_RD 2
`define ADCSH_CTRL_STEN 3

// Command byte: leading 0, read/write bit, then fixed pattern
`define ADCSH_CMD_PATTERN 6'h14
`define ADCSH_CMD_WRITE 1'h0
`define ADCSH_CMD_READ 1'h1

// Configuration byte fields
`define ADCSH_CFG_STEN 4
`define ADCSH_CFG_SPAN 3
`define ADCSH_CFG_HIZ 2
`define ADCSH_CFG_LATE 1
`define ADCSH_CFG_OVN 0
`define ADCSH_CFG_RESET 8'h01

// Frame lengths in serial clock cycles
`define ADCSH_REG_BITS 6'h10
`define ADCSH_RES_BITS 6'h10
`define ADCSH_STS_BITS 6'h16

// Timing, ns and derived 50 MHz cycle counts
`define ADCSH_CLK_NS 20
`define ADCSH_TCONV_NS 320
`define ADCSH_QUIET1_NS 190
`define ADCSH_QUIET2_NS 60
`define ADCSH_TCONV_CYC ((`ADCSH_TCONV_NS + `ADCSH_CLK_NS - 1) / `ADCSH_CLK_NS)
`define ADCSH_QUIET1_CYC ((`ADCSH_QUIET1_NS + `ADCSH_CLK_NS - 1) / `ADCSH_CLK_NS)
`define ADCSH_QUIET2_CYC ((`ADCSH_QUIET2_NS + `ADCSH_CLK_NS - 1) / `ADCSH_CLK_NS)
`define ADCSH_DIV_RESET 8'h02

`endif

// ---- core/adcsh_host.sv ----
// Host controller for the serial converter configuration and readback port
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "adcsh_cfg.svh"
module adcsh_host
	import adcsh_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic convert_line,
	output logic serial_clock,
	output logic serial_data_in,
	input wire logic serial_data_out
);
	// ------------------------------------------------------------
	// Pin input and shifter
	// ------------------------------------------------------------
	logic misoSync;
	logic sclkRaw;
	logic mosiRaw;
	logic [7:0] div_q;
	adcsh_shift_if sh ();

	adcsh_sync u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pinIn(serial_data_out),
		.syncOut(misoSync)
	);

	adcsh_shifter u_shf (
		.clk(clk),
		.sys_rst(sys_rst),
		.halfDiv(div_q),
		.misoSync(misoSync),
		.sh(sh.shf),
		.sclk_q(sclkRaw),
		.mosi_q(mosiRaw)
	);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	adcsh_state_t state_q;
	adcsh_op_t op_q;
	logic cnv_q;
	logic [7:0] cfgWr_q;
	logic [7:0] cfgRd_q;
	logic [15:0] result_q;
	logic [5:0] status_q;
	logic statusOn_q;
	logic lateOn_q;
	logic busyFlag_q;
	logic done_q;
	logic pendConv_q;
	logic pendWr_q;
	logic pendRd_q;
	logic [7:0] wait_q;
	logic start_q;
	logic [5:0] bits_q;
	logic [23:0] tx_q;
	logic sclkOut_q;
	logic sdiOut_q;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	logic access;
	logic wrAccess;
	logic hitCtrl;
	logic hitCfgw;
	logic hitStat;
	logic hitRes;
	logic hitCfgr;
	logic hitDiv;
	logic hitAny;
	logic [31:0] rdMux;
	assign access = psel && penable && !pready;
	assign wrAccess = access && pwrite;
	assign hitCtrl = (paddr == `ADCSH_CTRL_OFS);
	assign hitCfgw = (paddr == `ADCSH_CFGW_OFS);
	assign hitStat = (paddr == `ADCSH_STAT_OFS);
	assign hitRes = (paddr == `ADCSH_RES_OFS);
	assign hitCfgr = (paddr == `ADCSH_CFGR_OFS);
	assign hitDiv = (paddr == `ADCSH_DIV_OFS);
	assign hitAny = hitCtrl | hitCfgw | hitStat | hitRes | hitCfgr | hitDiv;
	assign rdMux = hitCtrl ? {30'h0, lateOn_q, statusOn_q} :
		hitCfgw ? {24'h0, cfgWr_q} :
		hitStat ? {24'h0, status_q, done_q, busyFlag_q} :
		hitRes ? {16'h0, result_q} :
		hitCfgr ? {24'h0, cfgRd_q} :
		hitDiv ? {24'h0, div_q} : 32'h0;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= access;
			pslverr <= access && !hitAny;
			prdata <= (access && !pwrite) ? rdMux : 32'h0;
		end
	end

	// Command word: leading 0, direction, fixed pattern, data byte
	logic [7:0] cmdWr;
	logic [7:0] cmdRd;
	logic [7:0] wrByte;
	assign cmdWr = {1'b0, `ADCSH_CMD_WRITE, `ADCSH_CMD_PATTERN};
	assign cmdRd = {1'b0, `ADCSH_CMD_READ, `ADCSH_CMD_PATTERN};
	// Bit 0 forced high so data-in rests high for the next convert rise
	assign wrByte = {3'h0, cfgWr_q[4:1], 1'b1};

	// ------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------
	logic startWr;
	logic startRd;
	logic startConv;
	assign startWr = pendWr_q;
	assign startRd = !pendWr_q && pendRd_q;
	assign startConv = !pendWr_q && !pendRd_q && pendConv_q;
	assign sh.start = start_q;
	assign sh.bitCount = bits_q;
	assign sh.txWord = tx_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ADCSH_IDLE;
			op_q <= ADCSH_OP_CONV;
			cnv_q <= 1'b1;
			cfgWr_q <= `ADCSH_CFG_RESET;
			cfgRd_q <= `ADCSH_CFG_RESET;
			result_q <= 16'h0;
			status_q <= 6'h0;
			statusOn_q <= 1'b0;
			lateOn_q <= 1'b0;
			busyFlag_q <= 1'b0;
			done_q <= 1'b0;
			pendConv_q <= 1'b0;
			pendWr_q <= 1'b0;
			pendRd_q <= 1'b0;
			wait_q <= 8'h0;
			start_q <= 1'b0;
			bits_q <= 6'h0;
			tx_q <= 24'h0;
			div_q <= `ADCSH_DIV_RESET;
		end else begin
			start_q <= 1'b0;
			if (wrAccess && hitCfgw) begin
				cfgWr_q <= pwdata[7:0];
			end
			if (wrAccess && hitDiv) begin
				div_q <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
			end
			// Done is write-one-to-clear; a new completion wins over the clear
			if (wrAccess && hitStat && pwdata[1]) begin
				done_q <= 1'b0;
			end
			if (wrAccess && hitCtrl) begin
				pendConv_q <= pendConv_q | pwdata[`ADCSH_CTRL_CONV];
				pendWr_q <= pendWr_q | pwdata[`ADCSH_CTRL_WR];
				// Only a single device is assumed, so reads are allowed
				pendRd_q <= pendRd_q | pwdata[`ADCSH_CTRL_RD];
			end
			case (state_q)
				ADCSH_IDLE: begin
					if (startWr || startRd || startConv) begin
						busyFlag_q <= 1'b1;
						state_q <= ADCSH_CONV;
						// Convert is already high since the gap; conversion time also serves as quiet time
						cnv_q <= 1'b1;
						wait_q <= 8'(`ADCSH_TCONV_CYC);
						if (startWr) begin
							op_q <= ADCSH_OP_WR;
							pendWr_q <= 1'b0;
						end else if (startRd) begin
							op_q <= ADCSH_OP_RD;
							pendRd_q <= 1'b0;
						end else begin
							op_q <= ADCSH_OP_CONV;
							pendConv_q <= 1'b0;
						end
					end
				end
				ADCSH_CONV: begin
					// Convert held high, no clock edges for the full conversion
					if (wait_q > 8'h01) begin
						wait_q <= wait_q - 8'h01;
					end else begin
						wait_q <= 8'(`ADCSH_QUIET1_CYC);
						state_q <= ADCSH_QUIET;
					end
				end
				ADCSH_QUIET: begin
					// Quiet-after-convert before lowering convert
					if (wait_q > 8'h01) begin
						wait_q <= wait_q - 8'h01;
					end else begin
						cnv_q <= 1'b0;
						start_q <= 1'b1;
						state_q <= ADCSH_SHIFT;
						if (op_q == ADCSH_OP_CONV) begin
							// Status bits extend the frame to 22 edges
							// All six are clocked out; stopping early would save little
							bits_q <= statusOn_q ? `ADCSH_STS_BITS : `ADCSH_RES_BITS;
							tx_q <= 24'hFFFFFF;
						end else begin
							// Register frame shares the readback slot of this conversion
							bits_q <= `ADCSH_REG_BITS;
							tx_q <= (op_q == ADCSH_OP_WR) ? {cmdWr, wrByte, 8'hFF} :
								{cmdRd, 8'hFF, 8'hFF};
						end
					end
				end
				ADCSH_SHIFT: begin
					if (sh.done) begin
						state_q <= ADCSH_GAP;
						wait_q <= 8'(`ADCSH_QUIET2_CYC);
						done_q <= 1'b1;
						case (op_q)
							ADCSH_OP_WR: begin
								// Shadow of the written enables
								statusOn_q <= cfgWr_q[`ADCSH_CFG_STEN];
								lateOn_q <= cfgWr_q[`ADCSH_CFG_LATE];
							end
							ADCSH_OP_RD: begin
								// Data byte carries the register, MSB first
								cfgRd_q <= sh.rxWord[7:0];
							end
							default: begin
								// Result first, then status MSB first
								if (statusOn_q) begin
									result_q <= sh.rxWord[21:6];
									status_q <= sh.rxWord[5:0];
								end else begin
									result_q <= sh.rxWord[15:0];
								end
							end
						endcase
					end
				end
				ADCSH_GAP: begin
					// Quiet-before-convert after last falling edge
					if (wait_q > 8'h01) begin
						wait_q <= wait_q - 8'h01;
					end else begin
						cnv_q <= 1'b1;
						busyFlag_q <= 1'b0;
						state_q <= ADCSH_IDLE;
					end
				end
				default: begin
					state_q <= ADCSH_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pin outputs, registered
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclkOut_q <= 1'b0;
			sdiOut_q <= 1'b1;
		end else begin
			sclkOut_q <= sclkRaw;
			sdiOut_q <= mosiRaw;
		end
	end
	assign convert_line = cnv_q;
	assign serial_clock = sclkOut_q;
	assign serial_data_in = sdiOut_q;
endmodule

// ---- core/adcsh_pkg.sv ----
// Types of the serial converter host
package adcsh_pkg;
	typedef enum logic [2:0] {
		ADCSH_IDLE,
		ADCSH_CONV,
		ADCSH_QUIET,
		ADCSH_SHIFT,
		ADCSH_GAP
	} adcsh_state_t;
	typedef enum logic [1:0] {
		ADCSH_OP_CONV,
		ADCSH_OP_WR,
		ADCSH_OP_RD
	} adcsh_op_t;
endpackage

// ---- core/adcsh_shift_if.sv ----
// Handshake between the frame sequencer and the serial shifter
`timescale 1ns/1ns
interface adcsh_shift_if;
	logic start;
	logic [5:0] bitCount;
	logic [23:0] txWord;
	logic busy;
	logic done;
	logic [23:0] rxWord;
	modport seq (output start, output bitCount, output txWord,
		input busy, input done, input rxWord);
	modport shf (input start, input bitCount, input txWord,
		output busy, output done, output rxWord);
endinterface

// ---- core/adcsh_shifter.sv ----
// Mode 0 serial shifter: idle-low clock, data out before rise, capture at the end of the high phase
`timescale 1ns/1ns
module adcsh_shifter
	import adcsh_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] halfDiv,
	input wire logic misoSync,
	adcsh_shift_if.shf sh,
	output logic sclk_q,
	output logic mosi_q
);
	logic [5:0] left_q;
	logic [7:0] div_q;
	logic [23:0] tx_q;
	logic [23:0] rx_q;
	logic done_q;
	logic tick;
	assign tick = (div_q == 8'h00);
	assign sh.busy = (left_q != 6'h00);
	assign sh.done = done_q;
	assign sh.rxWord = rx_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			left_q <= 6'h00;
			div_q <= 8'h00;
			tx_q <= 24'h000000;
			rx_q <= 24'h000000;
			sclk_q <= 1'b0;
			mosi_q <= 1'b1;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (sh.start && left_q == 6'h00) begin
				left_q <= sh.bitCount;
				tx_q <= sh.txWord << 1;
				mosi_q <= sh.txWord[23];
				rx_q <= 24'h000000;
				div_q <= halfDiv;
				sclk_q <= 1'b0;
			end else if (left_q != 6'h00) begin
				div_q <= tick ? halfDiv : div_q - 8'h01;
				if (tick && !sclk_q) begin
					sclk_q <= 1'b1;
				end else if (tick) begin
					// Capture at the end of the high phase: the pin lags by one cycle and
					// the synchroniser by two more, and the bit holds until the next fall
					rx_q <= {rx_q[22:0], misoSync};
					// Falling edge presents the next bit
					sclk_q <= 1'b0;
					mosi_q <= tx_q[23];
					tx_q <= tx_q << 1;
					left_q <= left_q - 6'h01;
					done_q <= (left_q == 6'h01);
				end
			end else begin
				// Data-in rests high between frames
				mosi_q <= 1'b1;
			end
		end
	end
endmodule

// ---- core/adcsh_sync.sv ----
// Two flip-flop synchroniser for a pin input
`timescale 1ns/1ns
module adcsh_sync (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pinIn,
	output logic syncOut
);
	logic meta_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			syncOut <= 1'b0;
		end else begin
			meta_q <= pinIn;
			syncOut <= meta_q;
		end
	end
endmodule

// ---- testbench/adcsh_dev_model.sv ----
// Behavioural model of the converter's serial port
`timescale 1ns/1ns
module adcsh_dev_model #(
	parameter logic [15:0] RES_BASE = 16'h3A50
) (
	input wire logic convert_line,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	output logic serial_data_out
);
	logic [7:0] cfgQ = 8'h01;
	logic [15:0] curRes = RES_BASE;
	logic [15:0] prevRes = RES_BASE;
	logic [21:0] word = 22'h000000;
	logic [15:0] rx = 16'h0000;
	logic [7:0] cmdQ = 8'hFF;
	logic lastBit = 1'b0;
	int bitNo = 0;
	int protoErr = 0;
	wire cmdHit = !cmdQ[7] && cmdQ[5:0] == 6'h14;
	task automatic put(input logic b);
		serial_data_out = b;
		lastBit = b;
	endtask
	// No pull-up on the line, so a floating output shows the inverse of the last bit
	initial serial_data_out = 1'b1;
	always @(posedge convert_line) begin
		if (!serial_data_in)
			protoErr++;
		prevRes = curRes;
		curRes = curRes + 16'h0001;
		serial_data_out = ~lastBit;
	end
	always @(negedge convert_line) begin
		bitNo = 0;
		cmdQ = 8'hFF;
		word = {cfgQ[1] ? prevRes : curRes, cfgQ[0], cfgQ[3:1], 2'b00};
		put(word[21]);
	end
	always @(posedge serial_clock) begin
		if (convert_line)
			protoErr++;
		rx = {rx[14:0], serial_data_in};
		if (bitNo == 7)
			cmdQ = rx[7:0];
		if (bitNo == 15 && cmdHit && !cmdQ[6])
			cfgQ[4:1] = rx[4:1];
	end
	always @(negedge serial_clock) begin
		bitNo++;
		if (bitNo >= 8 && bitNo < 16 && cmdHit && cmdQ[6])
			put(cfgQ[15 - bitNo]);
		else if (bitNo < 16 || (bitNo < 22 && cfgQ[4]))
			put(word[21 - bitNo]);
		else
			serial_data_out = ~lastBit;
	end
endmodule

// ---- testbench/adcsh_host_props.sv ----
// Port-level checks of the serial converter host
`timescale 1ns/1ns
module adcsh_host_props (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic convert_line,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	input wire logic serial_data_out
);
	// ----
	// Frame trackers
	// ----
	localparam int HIGH_MIN = 26;
	logic sclkPrev_q;
	logic [4:0] falls_q;
	logic [3:0] rises_q;
	logic [7:0] cmd_q;
	logic [5:0] high_q;
	wire sclkRise = serial_clock && !sclkPrev_q;
	wire sclkFall = !serial_clock && sclkPrev_q;
	wire highSat = high_q == 6'h3F;
	// Edge counters clear while convert is high so each frame starts from zero; high_q clears while it is low
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclkPrev_q <= 1'b0;
			falls_q <= 5'h00;
			rises_q <= 4'h0;
			cmd_q <= 8'hFF;
			high_q <= 6'h00;
		end else begin
			sclkPrev_q <= serial_clock;
			falls_q <= convert_line ? 5'h00 : falls_q + {4'h0, sclkFall};
			rises_q <= convert_line ? 4'h0 : rises_q + {3'h0, sclkRise && rises_q != 4'h8};
			if (convert_line)
				cmd_q <= 8'hFF;
			else if (sclkRise && rises_q != 4'h8)
				cmd_q <= {cmd_q[6:0], serial_data_in};
			high_q <= !convert_line ? 6'h00 : (highSat ? high_q : high_q + 6'h01);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_sclk_idle: assert property (convert_line |-> !serial_clock)
		else $error("serial clock active while convert is high");
	a_sdi_high: assert property (convert_line |-> serial_data_in)
		else $error("data-in low while convert is high");
	a_sdi_hold: assert property (serial_clock |-> $stable(serial_data_in))
		else $error("data-in changed while serial clock high");
	a_frame_len: assert property ($rose(convert_line) |-> falls_q == 5'h10 || falls_q == 5'h16)
		else $error("frame did not carry 16 or 22 clocks");
	a_cmd_pattern: assert property (rises_q == 4'h8 && !cmd_q[7] |-> cmd_q[5:0] == 6'h14)
		else $error("register command with wrong fixed bits");
	a_quiet_after: assert property ($fell(convert_line) |-> high_q >= HIGH_MIN)
		else $error("convert lowered too soon after rising");
	a_quiet_before: assert property ($rose(convert_line) |->
		!$past(serial_clock, 1) && !$past(serial_clock, 2) && !$past(serial_clock, 3))
		else $error("convert raised too soon after last clock");
	a_apb_answer: assert property (psel && penable && !pready |=> pready && !$past(pready))
		else $error("access not answered in the next cycle");
	a_apb_pulse: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	a_err_pair: assert property (pslverr |-> pready && psel)
		else $error("error flag without ready");
	a_rd_idle: assert property (!pready |-> prdata == 32'h00000000)
		else $error("read data not zero outside answer");
endmodule
bind adcsh_host adcsh_host_props adcsh_host_props_inst (.clk, .sys_rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .convert_line, .serial_clock,
	.serial_data_in, .serial_data_out);

// ---- testbench/adcsh_host_tb.sv ----
// Self-checking bench of the serial converter host
`timescale 1ns/1ns
`include "adcsh_cfg.svh"
module adcsh_host_tb;
	localparam logic [15:0] BASE = 16'h3A50;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, convert_line, serial_clock, serial_data_in, serial_data_out;
	logic [31:0] rdData;
	logic rdErr;
	int numErrors = 0;
	int nCompared = 0;
	int nConv = 0;
	always #10 clk = ~clk;
	adcsh_host adcsh_host_inst (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .convert_line, .serial_clock, .serial_data_in,
		.serial_data_out);
	adcsh_dev_model #(.RES_BASE(BASE)) adcsh_dev_model_inst (.convert_line, .serial_clock,
		.serial_data_in, .serial_data_out);
	// ----
	// Shared tasks
	// ----
	task automatic print_verdict;
		$display("compared=%0d mismatches=%0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			numErrors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] expRes(input int k);
		return {16'h0000, BASE + 16'(k)};
	endfunction
	// Ready is taken at the rising edge; only the watchdog ends a wait that never ends
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic runOp(input int ctrlBit);
		int i = 0;
		apb(1'b1, `ADCSH_CTRL_OFS, 32'h00000001 << ctrlBit);
		nConv++;
		do begin
			apb(1'b0, `ADCSH_STAT_OFS, 32'h00000000);
			i++;
		end while (rdData[1] !== 1'b1 && i < 200);
		chk({31'h00000000, rdData[1]}, 32'h00000001);
		apb(1'b1, `ADCSH_STAT_OFS, 32'h00000002);
	endtask
	task automatic chkRes(input int k);
		apb(1'b0, `ADCSH_RES_OFS, 32'h00000000);
		chk(rdData, expRes(k));
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_regs;
		apb(1'b0, `ADCSH_DIV_OFS, 32'h00000000);
		chk(rdData, {24'h000000, `ADCSH_DIV_RESET});
		apb(1'b0, 12'h020, 32'h00000000);
		chk(rdData, 32'h00000000);
		chk({31'h00000000, rdErr}, 32'h00000001);
		$display("test regs done");
	endtask
	task automatic t_plain;
		runOp(`ADCSH_CTRL_CONV);
		chkRes(nConv);
		$display("test plain done");
	endtask
	task automatic t_cfg;
		apb(1'b1, `ADCSH_CFGW_OFS, 32'h0000001C);
		runOp(`ADCSH_CTRL_WR);
		chk({24'h000000, adcsh_dev_model_inst.cfgQ}, 32'h0000001D);
		runOp(`ADCSH_CTRL_RD);
		apb(1'b0, `ADCSH_CFGR_OFS, 32'h00000000);
		chk(rdData, 32'h0000001D);
		runOp(`ADCSH_CTRL_CONV);
		chkRes(nConv);
		apb(1'b0, `ADCSH_STAT_OFS, 32'h00000000);
		chk({26'h0000000, rdData[7:2]}, 32'h00000038);
		chk({24'h000000, adcsh_dev_model_inst.cfgQ}, 32'h0000001D);
		$display("test cfg done");
	endtask
	task automatic t_late;
		apb(1'b1, `ADCSH_CFGW_OFS, 32'h00000002);
		runOp(`ADCSH_CTRL_WR);
		apb(1'b0, `ADCSH_CTRL_OFS, 32'h00000000);
		chk(rdData, 32'h00000002);
		runOp(`ADCSH_CTRL_CONV);
		chkRes(nConv - 1);
		runOp(`ADCSH_CTRL_CONV);
		chkRes(nConv - 1);
		chk(32'(adcsh_dev_model_inst.protoErr), 32'h00000000);
		$display("test late done");
	endtask
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs;
		t_plain;
		t_cfg;
		t_late;
		print_verdict;
	end
	initial begin
		#400000;
		numErrors++;
		print_verdict;
	end
endmodule
